// >>> logic/local_memory_select_decode.v
// local memory address line and chip select decoder
`include "lmsel_defines.vh"
module local_memory_select_decode (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        micro_load,
   input  wire [15:0] micro_in,
   input  wire        run_state_level,
   input  wire        hold_inactive_level,
   input  wire        source_enable_level,
   input  wire        sink_enable_level,
   input  wire        processor_clear_pulse,
   output reg  [15:0] micro_operator_bus,
   output reg         local_mem_addr_bit_three,
   output reg         local_mem_addr_bit_two,
   output reg         local_mem_addr_bit_one,
   output reg         local_mem_addr_bit_zero,
   output reg  [5:0]  first_group_chip_selects,
   output reg  [2:0]  second_group_chip_selects,
   output reg         register_move_micro,
   output reg  [3:0]  stack_top_word,
   output reg         pointer_half_bit
);
   reg        src_prev_reg;
   reg        snk_prev_reg;
   reg        pop_pending_reg;

   wire [3:0] ptr_value;
   wire       ptr_half;

   wire       effective;
   wire [3:0] op;
   wire [1:0] src_group;
   wire [1:0] src_select;
   wire [1:0] snk_group;
   wire [1:0] snk_select;
   wire [3:0] pad_word;

   wire       is_reg_move;
   wire       is_stack_move;
   wire       stack_is_sink;
   wire       stack_is_source;
   wire       sink_start;
   wire       source_end;
   wire       count_up;
   wire       count_down;
   wire [3:0] push_ptr;

   reg  [3:0] addr_next;
   reg  [5:0] first_cs_next;
   reg  [2:0] second_cs_next;

   reg  [12:0] src_sel;
   reg  [12:0] snk_sel;

   // register address table: group 3/2 is logic, 2/2 is transform
   function [3:0] reg_addr;
      input [1:0] group;
      input [1:0] select;
      begin
         if (group == `LOGIC_GROUP && select == `LOGIC_SELECT)
            reg_addr = `LOGIC_ADDR;
         else if (group == `XFORM_GROUP && select == `XFORM_SELECT)
            reg_addr = `XFORM_ADDR;
         else
            reg_addr = {group, select};
      end
   endfunction

   // packs {addr, first cs, second cs}; upper groups live in first data
   function [12:0] reg_sel;
      input [1:0] group;
      input [1:0] select;
      begin
         if (group[1])
            reg_sel = {reg_addr(group, select), `FIRST_CS_ALL, 3'h0};
         else
            reg_sel = {reg_addr(group, select), 6'h00, `SECOND_CS_ALL};
      end
   endfunction

   // stack words 0-7 in first half, 8-15 in second
   function [12:0] stack_sel;
      input [3:0] ptr;
      begin
         if (ptr[3])
            stack_sel = {1'b0, ptr[2:0], 6'h00, `SECOND_CS_ALL};
         else
            stack_sel = {1'b0, ptr[2:0], `FIRST_CS_ALL, 3'h0};
      end
   endfunction

   // left pad is first data, right pad second data
   function [12:0] pad_sel;
      input       right;
      input [3:0] word;
      begin
         if (right)
            pad_sel = {word, 6'h00, `SECOND_CS_ALL};
         else
            pad_sel = {word, `FIRST_CS_ALL, 3'h0};
      end
   endfunction

   // micro register feeding the distribution bus
   always @(posedge clk) begin
      if (!rst_b)
         micro_operator_bus <= `MICRO_RESET;
      else if (micro_load && effective)
         micro_operator_bus <= micro_in;
   end

   // run and hold gate both the load and every decode below
   assign effective  = run_state_level & hold_inactive_level;
   assign op         = micro_operator_bus[`OP_MSB:`OP_LSB];
   assign src_group  = micro_operator_bus[`SRC_GROUP_MSB:`SRC_GROUP_LSB];
   assign src_select = micro_operator_bus[`SRC_SELECT_MSB:`SRC_SELECT_LSB];
   assign snk_group  = micro_operator_bus[`SNK_GROUP_MSB:`SNK_GROUP_LSB];
   assign snk_select = micro_operator_bus[`SNK_SELECT_MSB:`SNK_SELECT_LSB];
   assign pad_word   = micro_operator_bus[`PAD_WORD_MSB:`PAD_WORD_LSB];

   assign is_reg_move     = effective && (op == `OP_REG_MOVE);
   assign is_stack_move   = effective && (op == `OP_STACK_MOVE);
   assign stack_is_sink   = is_stack_move & micro_operator_bus[`STK_DIR_BIT];
   assign stack_is_source = is_stack_move & ~micro_operator_bus[`STK_DIR_BIT];

   // push on the first sink cycle, pop once the source window closes
   assign sink_start = sink_enable_level & ~snk_prev_reg;
   assign source_end = ~source_enable_level & src_prev_reg;
   assign count_up   = stack_is_sink & sink_start;
   assign count_down = pop_pending_reg & source_end & ~count_up;

   // the write must see the incremented value on the same cycle
   assign push_ptr = ptr_value + 4'h1;

   always @(posedge clk) begin
      if (!rst_b || processor_clear_pulse) begin
         src_prev_reg    <= 1'b0;
         snk_prev_reg    <= 1'b0;
         pop_pending_reg <= 1'b0;
      end else begin
         // enable history, so a long window counts only once
         src_prev_reg <= source_enable_level;
         snk_prev_reg <= sink_enable_level;
         if (source_enable_level && stack_is_source)
            pop_pending_reg <= 1'b1;
         else if (source_end)
            pop_pending_reg <= 1'b0;
      end
   end

   // pointer moves at most once per micro window
   stack_pointer u_stack_pointer (
      .clk                   (clk),
      .rst_b                 (rst_b),
      .processor_clear_pulse (processor_clear_pulse),
      .count_up              (count_up),
      .count_down            (count_down),
      .pointer_value         (ptr_value),
      .pointer_half_bit      (ptr_half),
      .low_carry_out         ()
   );

   // source and sink selections before timing gates them
   always @* begin
      src_sel = 13'h0000;
      snk_sel = 13'h0000;
      if (is_reg_move) begin
         src_sel = reg_sel(src_group, src_select);
         snk_sel = reg_sel(snk_group, snk_select);
      end else if (stack_is_source) begin
         // pop reads the old pointer; it moves when the window closes
         src_sel = stack_sel(ptr_value);
         snk_sel = pad_sel(micro_operator_bus[`STK_PAD_RIGHT_BIT], pad_word);
      end else if (stack_is_sink) begin
         src_sel = pad_sel(micro_operator_bus[`STK_PAD_RIGHT_BIT], pad_word);
         snk_sel = stack_sel(sink_start ? push_ptr : ptr_value);
      end
   end

   // source precedes sink; both enables together favour the source
   always @* begin
      addr_next      = `ADDR_RESET;
      first_cs_next  = 6'h00;
      second_cs_next = 3'h0;
      if (source_enable_level) begin
         addr_next      = src_sel[12:9];
         first_cs_next  = src_sel[8:3];
         second_cs_next = src_sel[2:0];
      end else if (sink_enable_level) begin
         addr_next      = snk_sel[12:9];
         first_cs_next  = snk_sel[8:3];
         second_cs_next = snk_sel[2:0];
      end
   end

   // registered outputs; lines follow the enables by one clock
   always @(posedge clk) begin
      if (!rst_b) begin
         local_mem_addr_bit_three  <= 1'b0;
         local_mem_addr_bit_two    <= 1'b0;
         local_mem_addr_bit_one    <= 1'b0;
         local_mem_addr_bit_zero   <= 1'b0;
         first_group_chip_selects  <= 6'h00;
         second_group_chip_selects <= 3'h0;
         register_move_micro       <= 1'b0;
         stack_top_word            <= 4'h0;
         pointer_half_bit          <= 1'b0;
      end else begin
         local_mem_addr_bit_three  <= addr_next[3];
         local_mem_addr_bit_two    <= addr_next[2];
         local_mem_addr_bit_one    <= addr_next[1];
         local_mem_addr_bit_zero   <= addr_next[0];
         first_group_chip_selects  <= first_cs_next;
         second_group_chip_selects <= second_cs_next;
         register_move_micro       <= is_reg_move;
         // shows the pointer a cycle late; clear reads zero here too
         stack_top_word            <= processor_clear_pulse ? 4'h0 : ptr_value;
         pointer_half_bit          <= processor_clear_pulse ? 1'b0 : ptr_half;
      end
   end
endmodule // local_memory_select_decode

// >>> logic/lmsel_defines.vh
// constants for the local memory address and chip select decoder
// Overview of operation
// - four address lines, nine chip select levels
// - stack top access uses pointer, not fields
// - micro register held, sixteen bits broadcast
// - decode source and sink group and select
// - addresses and selects formed under timing control
// - register move micro: group 3/2 to 2/2
// - decode effective only with run and not hold
// - logic register source asserts six first selects
// - logic register source drives address bits 1,0
// - transform register sink asserts six first selects
// - transform register sink drives address bit 1
// - stack words 0-7 first half, 8-15 second
// - source pop decrements after the read
// - sink push increments before the write
// - pointer top bit selects the stack half
// - processor clear zeroes both pointer halves
`ifndef LMSEL_DEFINES_VH
`define LMSEL_DEFINES_VH
`define MICRO_WIDTH        16
`define MICRO_RESET        16'h0000
`define OP_MSB             15
`define OP_LSB             12
`define OP_REG_MOVE        4'h1
`define OP_STACK_MOVE      4'h2
`define SRC_GROUP_MSB      11
`define SRC_GROUP_LSB      10
`define SRC_SELECT_MSB     9
`define SRC_SELECT_LSB     8
`define SNK_GROUP_MSB      7
`define SNK_GROUP_LSB      6
`define SNK_SELECT_MSB     5
`define SNK_SELECT_LSB     4
`define STK_DIR_BIT        11
`define STK_PAD_RIGHT_BIT  10
`define PAD_WORD_MSB       3
`define PAD_WORD_LSB       0
`define LOGIC_GROUP        2'h3
`define LOGIC_SELECT       2'h2
`define XFORM_GROUP        2'h2
`define XFORM_SELECT       2'h2
`define LOGIC_ADDR         4'h3
`define XFORM_ADDR         4'h2
`define FIRST_CS_ALL       6'h3f
`define SECOND_CS_ALL      3'h7
`define ADDR_RESET         4'h0
`define PTR_RESET          3'h0
`endif

// >>> logic/stack_pointer.v
// stack pointer built from two three-bit counting halves
`include "lmsel_defines.vh"
module stack_pointer (
   input  wire       clk,
   input  wire       rst_b,
   input  wire       processor_clear_pulse,
   input  wire       count_up,
   input  wire       count_down,
   output wire [3:0] pointer_value,
   output wire       pointer_half_bit,
   output wire       low_carry_out
);
   reg [2:0] low_reg;
   reg [2:0] high_reg;
   reg [2:0] low_next;
   reg [2:0] high_next;

   // carry or borrow sensed without a clock, as the halves chain
   assign low_carry_out = (count_up & (low_reg == 3'h7)) |
                          (count_down & (low_reg == 3'h0));

   always @* begin
      low_next  = low_reg;
      high_next = high_reg;
      if (count_up) begin
         low_next  = low_reg + 3'h1;
         high_next = low_carry_out ? high_reg + 3'h1 : high_reg;
      end else if (count_down) begin
         low_next  = low_reg - 3'h1;
         high_next = low_carry_out ? high_reg - 3'h1 : high_reg;
      end
   end

   always @(posedge clk) begin
      if (!rst_b || processor_clear_pulse) begin
         low_reg  <= `PTR_RESET;
         high_reg <= `PTR_RESET;
      end else begin
         low_reg  <= low_next;
         high_reg <= high_next;
      end
   end

   // only bit zero of the upper half is used: sixteen stack words
   assign pointer_value    = {high_reg[0], low_reg};
   assign pointer_half_bit = high_reg[0];
endmodule // stack_pointer

// >>> tb/lmsel_timing_model.sv
// partner: micro timing logic giving source then sink enable windows
module lmsel_timing_model (
   input  wire clk,
   input  wire rst_b,
   input  wire start,
   input  wire slow,
   output reg  source_enable_level,
   output reg  sink_enable_level
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [1:0] len_reg;
   // source window always ends before sink opens, never overlapping
   always @(posedge clk) begin
      if (!rst_b) begin
         source_enable_level <= 1'h0;
         sink_enable_level   <= 1'h0;
         len_reg             <= 2'h0;
      end else if (len_reg != 2'h0) begin
         len_reg <= len_reg - 2'h1;
      end else if (source_enable_level) begin
         source_enable_level <= 1'h0;
         sink_enable_level   <= 1'h1;
         len_reg             <= slow ? 2'h2 : 2'h0;
      end else if (sink_enable_level) begin
         sink_enable_level <= 1'h0;
      end else if (start) begin
         source_enable_level <= 1'h1;
         len_reg             <= slow ? 2'h2 : 2'h0;
      end
   end
endmodule // lmsel_timing_model

// >>> tb/local_memory_select_decode_asserts.sv
// checker: port-level assertions for the local memory select decoder
module lmsel_chk (
   input wire        clk,
   input wire        rst_b,
   input wire        micro_load,
   input wire [15:0] micro_in,
   input wire        run_state_level,
   input wire        hold_inactive_level,
   input wire        source_enable_level,
   input wire        sink_enable_level,
   input wire        processor_clear_pulse,
   input wire [15:0] micro_operator_bus,
   input wire        local_mem_addr_bit_three,
   input wire        local_mem_addr_bit_two,
   input wire        local_mem_addr_bit_one,
   input wire        local_mem_addr_bit_zero,
   input wire [5:0]  first_group_chip_selects,
   input wire [2:0]  second_group_chip_selects,
   input wire        register_move_micro,
   input wire [3:0]  stack_top_word,
   input wire        pointer_half_bit
);
   timeunit 1ns;
   timeprecision 100ps;
   wire       go  = run_state_level & hold_inactive_level;
   wire       src = source_enable_level;
   wire       snk = sink_enable_level;
   wire       mv  = micro_operator_bus == 16'h1ea0;
   wire [3:0] ad  = {local_mem_addr_bit_three, local_mem_addr_bit_two,
                     local_mem_addr_bit_one, local_mem_addr_bit_zero};
   wire [8:0] cs  = {first_group_chip_selects, second_group_chip_selects};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   move_source_a:
   assert property (src && go && mv |=> ad == 4'h3 && cs == 9'h1f8) else $error("move source");
   move_sink_a:
   assert property (!src && snk && go && mv |=> ad == 4'h2 && cs == 9'h1f8) else $error("move sink");
   idle_selects_a:
   assert property (!src && !snk |=> cs == 9'h0 && ad == 4'h0) else $error("idle selects");
   decode_blocked_a:
   assert property (!go |=> cs == 9'h0) else $error("decode not blocked");
   load_taken_a:
   assert property (micro_load && go |=> micro_operator_bus == $past(micro_in))
      else $error("micro not loaded");
   load_refused_a:
   assert property (micro_load && !go |=> $stable(micro_operator_bus)) else $error("load taken");
   half_bit_a:
   assert property (pointer_half_bit == stack_top_word[3]) else $error("half bit");
   clear_zero_a:
   assert property (processor_clear_pulse && !src && !snk |=> stack_top_word == 4'h0)
      else $error("pointer not cleared");
endmodule // lmsel_chk
bind local_memory_select_decode lmsel_chk u_chk (.*);

// >>> tb/tb_local_memory_select_decode.sv
// bench: random and corner stimulus for the local memory select decoder
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_local_memory_select_decode;
   timeunit 1ns;
   timeprecision 100ps;
   reg         clk = 1'h0, rst_b = 1'h0, micro_load = 1'h0, start = 1'h0, slow = 1'h0;
   reg         run_state_level = 1'h1, hold_inactive_level = 1'h1, processor_clear_pulse = 1'h0;
   reg  [15:0] micro_in = 16'h0000, r = 16'h4107, mb = 16'h0000;
   reg  [3:0]  ptr = 4'h0;
   integer     n_errors = 0, total_checks = 0, i;
   wire [15:0] micro_operator_bus;
   wire        b3, b2, b1, b0, src, snk, rmm, half;
   wire [5:0]  fcs;
   wire [2:0]  scs;
   wire [3:0]  stack_top_word;
   wire [3:0]  ad = {b3, b2, b1, b0};
   wire [8:0]  cs = {fcs, scs};
   always #4 clk = ~clk;
   lmsel_timing_model tm (.clk(clk), .rst_b(rst_b), .start(start), .slow(slow),
      .source_enable_level(src), .sink_enable_level(snk));
   local_memory_select_decode dut (.clk(clk), .rst_b(rst_b), .micro_load(micro_load),
      .micro_in(micro_in), .run_state_level(run_state_level),
      .hold_inactive_level(hold_inactive_level), .source_enable_level(src),
      .sink_enable_level(snk), .processor_clear_pulse(processor_clear_pulse),
      .micro_operator_bus(micro_operator_bus), .local_mem_addr_bit_three(b3),
      .local_mem_addr_bit_two(b2), .local_mem_addr_bit_one(b1), .local_mem_addr_bit_zero(b0),
      .first_group_chip_selects(fcs), .second_group_chip_selects(scs),
      .register_move_micro(rmm), .stack_top_word(stack_top_word), .pointer_half_bit(half));
   function [15:0] lf(input [15:0] v);
      lf = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // stack word lines: low half on first group, high half on second
   function [12:0] stk(input [3:0] p);
      stk = {1'h0, p[2:0], p[3] ? 9'h007 : 9'h1f8};
   endfunction
   task test_done;
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one micro cycle: lines checked every cycle against last sampled enables
   task mc(input [15:0] m, input [12:0] es, input [12:0] ek, input sl);
      integer k;
      reg     ps, pk, em;
      em = m[15:12] == 4'h1 && run_state_level && hold_inactive_level;
      micro_in = m;
      micro_load = 1'h1;
      slow = sl;
      @(posedge clk);
      #1 micro_load = 1'h0;
      start = 1'h1;
      @(posedge clk);
      #1 start = 1'h0;
      for (k = 0; k < 10; k++) begin
         ps = src;
         pk = snk;
         @(posedge clk);
         #1;
         `CHK("lines", ps ? es : pk ? ek : 13'h0, {ad, cs})
         `CHK("move", em, rmm)
      end
   endtask
   task clr;
      processor_clear_pulse = 1'h1;
      @(posedge clk);
      #1 processor_clear_pulse = 1'h0;
      `CHK("clear", 4'h0, stack_top_word)
   endtask
   initial begin
      #400000 n_errors++;
      test_done;
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_b = 1'h1;
      `CHK("reset", 33'h0, {micro_operator_bus, ad, cs, stack_top_word})
      micro_load = 1'h1;
      for (i = 0; i < 24; i++) begin
         r = lf(r);
         micro_in = r;
         run_state_level = r[0] | r[2];
         hold_inactive_level = r[1] | r[2];
         @(posedge clk);
         #1;
         if (run_state_level & hold_inactive_level) mb = r;
         `CHK("bus", mb, micro_operator_bus)
         `CHK("idle", 13'h0, {ad, cs})
      end
      micro_load = 1'h0;
      run_state_level = 1'h1;
      hold_inactive_level = 1'h1;
      mc(16'h1ea0, 13'h07f8, 13'h05f8, 1'h0);
      mc(16'h1ea0, 13'h07f8, 13'h05f8, 1'h1);
      mc(16'h15c0, 13'h0a07, 13'h19f8, 1'h0);
      hold_inactive_level = 1'h0;
      mc(16'h2803, 13'h0, 13'h0, 1'h0);
      hold_inactive_level = 1'h1;
      run_state_level = 1'h0;
      mc(16'h2803, 13'h0, 13'h0, 1'h1);
      run_state_level = 1'h1;
      clr;
      for (i = 0; i < 9; i++) begin
         mc(16'h2803, 13'h07f8, stk(ptr + 4'h1), i[0]);
         ptr = ptr + 4'h1;
         `CHK("top", ptr, stack_top_word)
         `CHK("half", ptr[3], half)
      end
      clr;
      ptr = 4'h0;
      for (i = 0; i < 9; i++) begin
         mc(16'h2405, stk(ptr), 13'h0a07, i[0]);
         ptr = ptr - 4'h1;
         `CHK("top", ptr, stack_top_word)
         `CHK("half", ptr[3], half)
      end
      rst_b = 1'h0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'h1;
      `CHK("reset", 33'h0, {micro_operator_bus, ad, cs, stack_top_word})
      mc(16'h2803, 13'h07f8, stk(4'h1), 1'h0);
      `CHK("top", 4'h1, stack_top_word)
      test_done;
   end
endmodule // tb_local_memory_select_decode
